// File: tma_fifo.sv
// Purpose: flip-flop fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes:   ready drops when full so the source must hold its word
`timescale 1ns/1ps
`default_nettype none
module tma_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  // fill and drain sides
  tma_fifo_if.snk   in_if,
  tma_fifo_if.src   out_if
);
  localparam int PW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wptr;
    logic [PW-1:0]       rptr;
    logic [PW:0]         cnt;
  } tma_fifo_st_t;

  tma_fifo_st_t r;
  tma_fifo_st_t next_r;
  logic         push;
  logic         pop;

  // honest full and empty from the fill count
  assign in_if.ready  = (r.cnt != D[PW:0]);
  assign out_if.valid = (r.cnt != '0);
  assign out_if.data  = r.mem[r.rptr];
  assign push = in_if.valid & in_if.ready;
  assign pop  = out_if.valid & out_if.ready;

  // pointer and count update
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wptr] = in_if.data;
      next_r.wptr = r.wptr + 1'b1;
    end
    if (pop) begin
      next_r.rptr = r.rptr + 1'b1;
    end
    if (push && !pop) begin
      next_r.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  // state register; storage itself needs no reset
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      r.mem  <= r.mem;
      r.wptr <= '0;
      r.rptr <= '0;
      r.cnt  <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

// File: tma_fifo_if.sv
// Purpose: valid/ready carrier between the map and its fifo
// Assumes: both ends on i_ref_clk
// Notes:   transfer happens when valid and ready are both high
`timescale 1ns/1ps
`default_nettype none
interface tma_fifo_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: tma_host_model.sv
// Purpose: host processor on the parallel non-multiplexed port
// Assumes: block answers by ack or by a select within a dozen cycles
// Notes:   released address and direction keep their last values four cycles, then show inverted values
`timescale 1ns/1ps
`default_nettype none
module tma_host_model (
  // clock
  input wire logic          i_ref_clk,
  // host pins
  output var logic          o_cs_n,
  output var logic          o_ds_n,
  output var logic          o_rd_wr,
  output var logic [14:0]   o_addr,
  // answers
  input wire logic [15:0]   i_data,
  input wire logic          i_dta_n,
  input wire logic [2:0]    i_sel
);
  initial begin
    o_cs_n = 1'b1;
    o_ds_n = 1'b1;
    o_rd_wr = 1'b1;
    o_addr = 15'h0000;
  end
  // one strobe per access; seen is {reg, local route, bp route, ack}
  task automatic access(input logic [14:0] a, input logic rd, output logic [15:0] d,
                        output logic [3:0] seen);
    int n;
    n = 0;
    seen = 4'h0;
    d = 16'h0000;
    @(posedge i_ref_clk);
    o_addr <= a;
    o_rd_wr <= rd;
    o_cs_n <= 1'b0;
    o_ds_n <= 1'b0;
    while (seen == 4'h0 && n < 12) begin
      @(posedge i_ref_clk);
      seen = {i_sel, ~i_dta_n};
      d = i_data;
      n++;
    end
    // answer taken at this edge; strobes released on the same edge
    o_cs_n <= 1'b1;
    o_ds_n <= 1'b1;
    // hold address until the selects have dropped, then drive its inverse
    repeat (4) @(posedge i_ref_clk);
    o_addr <= ~a;
    o_rd_wr <= ~rd;
    repeat (2) @(posedge i_ref_clk);
  endtask
endmodule
`default_nettype wire

// File: tma_map.sv
// Purpose: host address decode and receive timeslot data memories
// Assumes: host strobes and serial pins are asynchronous to i_ref_clk
// Notes:   control registers and route memories sit outside this block
//
// Notes on behaviour
// - top address bit low selects registers, high selects a memory
// - memory select field picks route or receive memory per side
// - address bits 13 to 9 give the stream, 0-15 local, 0-31 backplane
// - at top rate only local streams 0-7, backplane 0-15 are used
// - low nine address bits give the channel, 0 to 511
// - channel span doubles with rate: 31, 63, 127, 255, 511
// - separate local and backplane memories filled with deserialised bytes
// - local receive memory is 4096 bytes, one per stream and channel
// - local entry located by stream and channel of address bits 13-0
// - local receive memory cannot be written from the host
// - backplane memory is 8192 bytes, one per stream and channel, read-only
// - reads return byte in bits 7:0, zeros in bits 15:8
// - first bit received in a timeslot lands in stored bit 7
// - each byte entry is presented as a full 16-bit word
`timescale 1ns/1ps
`default_nettype none
module tma_map (
  // clock and reset
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_sys_rst,
  // host parallel port
  input  wire logic                          i_cs_n,
  input  wire logic                          i_ds_n,
  input  wire logic                          i_rd_wr,
  input  wire logic [tma_pkg::ADDR_W-1:0]    i_addr,
  output var  logic [tma_pkg::WORD_W-1:0]    o_data,
  output var  logic                          o_data_oe,
  output var  logic                          o_dta_n,
  // decode towards control registers and route memories
  input  wire logic [2:0]                    i_memory_select_field,
  output var  logic                          o_reg_sel,
  output var  logic                          o_local_route_sel,
  output var  logic                          o_backplane_route_sel,
  // serial receive pins, index 0 local, 1 backplane
  input  wire logic [1:0]                    i_rx_bit,
  input  wire logic [1:0]                    i_rx_bit_stb,
  input  wire logic [1:0]                    i_rx_frame,
  input  wire logic [1:0][2:0]               i_rx_rate,
  // receive status
  output var  logic [1:0]                    o_rx_overrun
);
  import tma_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    // per side pin sample: [5] bit, [4:2] rate, [1] frame, [0] strobe
    logic [1:0][5:0]              rx_s1;
    logic [1:0][5:0]              rx_s2;
    logic [1:0]                   stb_prev;
    logic [1:0]                   frm_prev;
    logic [2:0]                   h_s1;
    logic [2:0]                   h_s2;
    logic [ADDR_W-1:0]            a_s1;
    logic [ADDR_W-1:0]            a_s2;
    logic [1:0][7:0]              shreg;
    logic [1:0][2:0]              bitcnt;
    logic [1:0][4:0]              strm;
    logic [1:0][8:0]              chan;
    logic [1:0]                   pend_vld;
    logic [1:0][ENTRY_W-1:0]      pend;
    logic [1:0]                   overrun;
    tma_host_st_t                 hst;
    logic [WORD_W-1:0]            rdata;
    logic                         oe;
    logic                         dta_n;
    logic                         reg_sel;
    logic                         lroute;
    logic                         broute;
    logic [LOC_DEPTH-1:0][7:0]    loc_mem;
    logic [BP_DEPTH-1:0][7:0]     bp_mem;
  } tma_map_st_t;

  tma_map_st_t r;
  tma_map_st_t next_r;

  tma_fifo_if #(.W(ENTRY_W)) fill_if ();
  tma_fifo_if #(.W(ENTRY_W)) drain_if ();

  // ****************************************
  // decode helpers
  // ****************************************
  // top rate folds one stream bit into the channel
  function automatic logic [IDX_W-1:0] mem_index(
    input logic [4:0] strm,
    input logic [8:0] chan,
    input logic       r32
  );
    logic [IDX_W-1:0] idx;
    idx = r32 ? {strm[3:0], chan} : {strm, chan[7:0]};
    return idx;
  endfunction

  function automatic logic is_r32(input logic [2:0] rate);
    return rate >= RATE_32M;
  endfunction

  // highest channel for a rate
  function automatic logic [8:0] chan_max(input logic [2:0] rate);
    logic [2:0] sh;
    sh = is_r32(rate) ? (RATE_32M - RATE_2M) : (rate - RATE_2M);
    return (CHAN_BASE << sh) - 9'h001;
  endfunction

  // highest stream for a side and rate
  function automatic logic [4:0] strm_max(
    input logic       side,
    input logic [2:0] rate
  );
    logic [4:0] m;
    if (side) begin
      m = is_r32(rate) ? BP_SMAX32 : BP_SMAX;
    end else begin
      m = is_r32(rate) ? LOC_SMAX32 : LOC_SMAX;
    end
    return m;
  endfunction

  // ****************************************
  // fifo in the receive path
  // ****************************************
  tma_fifo #(
    .W (ENTRY_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .in_if     (fill_if),
    .out_if    (drain_if)
  );

  // local byte has priority; backplane waits in its pending slot
  assign fill_if.valid = r.pend_vld[0] | r.pend_vld[1];
  assign fill_if.data  = r.pend_vld[0] ? r.pend[0] : r.pend[1];
  // memory writes stall while the host holds a cycle open
  assign drain_if.ready = (r.hst == HS_IDLE);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [1:0]        taken;
    logic [4:0]        smax;
    logic [8:0]        cmax;
    logic [2:0]        rate;
    logic [7:0]        byte_v;
    logic [4:0]        h_strm;
    logic [8:0]        h_chan;
    logic              h_side;
    logic              h_ok;
    logic [7:0]        h_byte;
    logic [IDX_W-1:0]  d_idx;
    taken  = 2'b00;
    smax   = '0;
    cmax   = '0;
    rate   = '0;
    byte_v = '0;
    h_strm = '0;
    h_chan = '0;
    h_side = 1'b0;
    h_ok   = 1'b0;
    h_byte = '0;
    d_idx  = '0;
    next_r = r;

    // two-flop synchronisers for every host and serial pin
    for (int s = 0; s < 2; s++) begin
      // all three rate bits travel, so 16M and 32M stay apart
      next_r.rx_s1[s] = {i_rx_bit[s], i_rx_rate[s], i_rx_frame[s], i_rx_bit_stb[s]};
    end
    next_r.rx_s2 = r.rx_s1;
    next_r.h_s1  = {i_cs_n, i_ds_n, i_rd_wr};
    next_r.h_s2  = r.h_s1;
    next_r.a_s1  = i_addr;
    next_r.a_s2  = r.a_s1;

    // fifo acceptance frees the pending slot
    if (fill_if.ready) begin
      taken = r.pend_vld[0] ? 2'b01 : {r.pend_vld[1], 1'b0};
    end
    next_r.pend_vld = r.pend_vld & ~taken;

    // serial-to-parallel per side
    for (int s = 0; s < 2; s++) begin
      next_r.stb_prev[s] = r.rx_s2[s][0];
      next_r.frm_prev[s] = r.rx_s2[s][1];
      rate = r.rx_s2[s][4:2];
      smax = strm_max(s[0], rate);
      cmax = chan_max(rate);
      if (r.rx_s2[s][1] && !r.frm_prev[s]) begin
        // frame start realigns bit and slot position
        next_r.bitcnt[s] = '0;
        next_r.strm[s]   = '0;
        next_r.chan[s]   = '0;
      end else if (r.rx_s2[s][0] && !r.stb_prev[s]) begin
        // first bit shifts up to stored bit 7 after eight strobes
        byte_v = {r.shreg[s][6:0], r.rx_s2[s][5]};
        next_r.shreg[s]  = byte_v;
        next_r.bitcnt[s] = r.bitcnt[s] + 3'h1;
        if (r.bitcnt[s] == 3'h7) begin
          // bytes stored sequentially by stream and channel
          next_r.pend[s] = {s[0], mem_index(r.strm[s], r.chan[s],
                            is_r32(rate)), byte_v};
          if (r.pend_vld[s] && !taken[s]) begin
            next_r.overrun[s] = 1'b1; // older byte lost
          end
          next_r.pend_vld[s] = 1'b1;
          if (r.chan[s] >= cmax) begin
            next_r.chan[s] = '0;
            next_r.strm[s] = (r.strm[s] >= smax) ? 5'h00 : r.strm[s] + 5'h01;
          end else begin
            next_r.chan[s] = r.chan[s] + 9'h001;
          end
        end
      end
    end

    // drain fifo into the receive memories
    if (drain_if.valid && drain_if.ready) begin
      d_idx = drain_if.data[ENTRY_W-2:BYTE_W];
      if (drain_if.data[ENTRY_W-1]) begin
        next_r.bp_mem[d_idx] = drain_if.data[7:0];
      end else begin
        next_r.loc_mem[d_idx[11:0]] = drain_if.data[7:0];
      end
    end

    // host address fields
    h_strm = r.a_s2[STRM_HI:STRM_LO];
    h_chan = r.a_s2[CHAN_W-1:0];
    h_side = (i_memory_select_field == MS_BP_DATA);
    rate   = h_side ? r.rx_s2[1][4:2] : r.rx_s2[0][4:2];
    h_ok   = (h_strm <= strm_max(h_side, rate))
             && (h_chan <= chan_max(rate));
    d_idx  = mem_index(h_strm, h_chan, is_r32(rate));
    h_byte = h_side ? r.bp_mem[d_idx] : r.loc_mem[d_idx[11:0]];

    // host cycle handling
    case (r.hst)
      HS_IDLE: begin
        if (!r.h_s2[2] && !r.h_s2[1]) begin
          if (!r.a_s2[SPACE_B]) begin
            next_r.reg_sel = 1'b1;
            next_r.hst     = HS_PASS;
          end else begin
            case (i_memory_select_field)
              MS_LOC_ROUTE: begin
                next_r.lroute = 1'b1;
                next_r.hst    = HS_PASS;
              end
              MS_BP_ROUTE: begin
                next_r.broute = 1'b1;
                next_r.hst    = HS_PASS;
              end
              MS_LOC_DATA, MS_BP_DATA: begin
                // writes acknowledged but never stored
                next_r.dta_n = 1'b0;
                next_r.oe    = r.h_s2[0];
                next_r.rdata = {RSVD_HI, h_ok ? h_byte : 8'h00};
                next_r.hst   = HS_HOLD;
              end
              default: begin
                // unmapped select codes end quietly with a zero word
                next_r.dta_n = 1'b0;
                next_r.oe    = r.h_s2[0];
                next_r.rdata = '0;
                next_r.hst   = HS_HOLD;
              end
            endcase
          end
        end
      end
      HS_HOLD, HS_PASS: begin
        // stay until the host releases the strobe
        if (r.h_s2[2] || r.h_s2[1]) begin
          next_r.dta_n   = 1'b1;
          next_r.oe      = 1'b0;
          next_r.reg_sel = 1'b0;
          next_r.lroute  = 1'b0;
          next_r.broute  = 1'b0;
          next_r.hst     = HS_IDLE;
        end
      end
      default: begin
        next_r.hst = HS_IDLE;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  // memories keep contents over reset; control state is cleared
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      r         <= next_r;
      r.rx_s1   <= '0;
      r.rx_s2   <= '0;
      r.stb_prev <= '0;
      r.frm_prev <= '0;
      r.h_s1    <= 3'h7;
      r.h_s2    <= 3'h7;
      r.a_s1    <= '0;
      r.a_s2    <= '0;
      r.shreg   <= '0;
      r.bitcnt  <= '0;
      r.strm    <= '0;
      r.chan    <= '0;
      r.pend_vld <= '0;
      r.pend    <= '0;
      r.overrun <= '0;
      r.hst     <= HS_IDLE;
      r.rdata   <= '0;
      r.oe      <= 1'b0;
      r.dta_n   <= 1'b1;
      r.reg_sel <= 1'b0;
      r.lroute  <= 1'b0;
      r.broute  <= 1'b0;
      r.loc_mem <= r.loc_mem;
      r.bp_mem  <= r.bp_mem;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from state
  assign o_data                = r.rdata;
  assign o_data_oe             = r.oe;
  assign o_dta_n               = r.dta_n;
  assign o_reg_sel             = r.reg_sel;
  assign o_local_route_sel     = r.lroute;
  assign o_backplane_route_sel = r.broute;
  assign o_rx_overrun          = r.overrun;
endmodule
`default_nettype wire

// File: tma_map_properties.sv
// Purpose: port properties of the timeslot memory access map
// Assumes: host holds address and direction while a cycle is open
// Notes:   bound to every tma_map instance
`timescale 1ns/1ps
`default_nettype none
module tma_map_checker (
  // clock and reset
  input wire logic                         i_ref_clk,
  input wire logic                         i_sys_rst,
  // host port
  input wire logic                         i_ds_n,
  input wire logic                         i_rd_wr,
  input wire logic [tma_pkg::ADDR_W-1:0]   i_addr,
  input wire logic [2:0]                   i_memory_select_field,
  input wire logic [tma_pkg::WORD_W-1:0]   o_data,
  input wire logic                         o_data_oe,
  input wire logic                         o_dta_n,
  input wire logic                         o_reg_sel,
  input wire logic                         o_local_route_sel,
  input wire logic                         o_backplane_route_sel
);
  import tma_pkg::*;
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  property p_rst_idle;
    $fell(i_sys_rst) |-> o_dta_n && !o_data_oe && o_data == 16'h0000;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("bus not idle after reset");
  property p_hi_zero;
    o_data_oe |-> o_data[15:8] == RSVD_HI;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper byte not zero");
  property p_oe_ack;
    o_data_oe |-> !o_dta_n && i_rd_wr;
  endproperty
  a_oe_ack: assert property (p_oe_ack) else $error("bus driven outside a read");
  property p_reg_space;
    o_reg_sel |-> !i_addr[SPACE_B];
  endproperty
  a_reg_space: assert property (p_reg_space) else $error("register select wrong space");
  property p_loc_route;
    o_local_route_sel |-> i_addr[SPACE_B] && i_memory_select_field == MS_LOC_ROUTE;
  endproperty
  a_loc_route: assert property (p_loc_route) else $error("local route select wrong");
  property p_bp_route;
    o_backplane_route_sel |-> i_addr[SPACE_B] && i_memory_select_field == MS_BP_ROUTE;
  endproperty
  a_bp_route: assert property (p_bp_route) else $error("backplane route select wrong");
  property p_one_target;
    $onehot0({o_reg_sel, o_local_route_sel, o_backplane_route_sel, !o_dta_n});
  endproperty
  a_one_target: assert property (p_one_target) else $error("two targets at once");
  property p_ack_mem;
    $fell(o_dta_n) |-> i_addr[SPACE_B] && i_memory_select_field >= MS_LOC_DATA;
  endproperty
  a_ack_mem: assert property (p_ack_mem) else $error("ack outside data memory");
  property p_ack_hold;
    $fell(o_dta_n) |-> !o_dta_n [*2];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack too short");
  property p_ack_release;
    !o_dta_n && i_ds_n |-> ##[1:4] o_dta_n;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack not released");
  // main scenarios seen
  c_reg: cover property (o_reg_sel);
  c_rd_ack: cover property ($fell(o_dta_n) && i_rd_wr);
  c_wr_ack: cover property ($fell(o_dta_n) && !i_rd_wr);
endmodule
bind tma_map tma_map_checker u_chk (.i_ref_clk, .i_sys_rst, .i_ds_n, .i_rd_wr, .i_addr,
  .i_memory_select_field, .o_data, .o_data_oe, .o_dta_n, .o_reg_sel, .o_local_route_sel,
  .o_backplane_route_sel);
`default_nettype wire

// File: tma_memory_access_map_tb.sv
// Purpose: self-checking bench for the timeslot memory access map
// Assumes: 10 MHz clock, receive sides at the lowest rate until the range test sets local to the top rate
// Notes:   host cycles go through the host model
`timescale 1ns/1ps
`default_nettype none
module tdm_memory_access_map_tb;
  import tma_pkg::*;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic [2:0]       msel = MS_LOC_ROUTE;
  logic [1:0]       rx_bit = 2'b00;
  logic [1:0]       rx_stb = 2'b00;
  logic [1:0]       rx_frame = 2'b00;
  logic [1:0][2:0]  rx_rate = {RATE_2M, RATE_2M};
  logic             cs_n, ds_n, rd_wr, dta_n;
  logic [14:0]      addr;
  logic [15:0]      data;
  logic [2:0]       sel;
  logic             oe;
  logic             oe_seen = 1'b0;
  logic [1:0]       ovr;
  int               failures = 0;
  int               comparisons = 0;
  always #50 clk = ~clk;
  // bus drive level captured while the block acknowledges
  always @(posedge clk) begin
    if (!dta_n) begin
      oe_seen <= oe;
    end
  end
  // ****************************************
  // design and host
  // ****************************************
  tma_map dut_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_cs_n(cs_n), .i_ds_n(ds_n),
    .i_rd_wr(rd_wr), .i_addr(addr), .o_data(data), .o_data_oe(oe), .o_dta_n(dta_n),
    .i_memory_select_field(msel), .o_reg_sel(sel[2]), .o_local_route_sel(sel[1]),
    .o_backplane_route_sel(sel[0]), .i_rx_bit(rx_bit), .i_rx_bit_stb(rx_stb),
    .i_rx_frame(rx_frame), .i_rx_rate(rx_rate), .o_rx_overrun(ovr));
  tma_host_model host_u (.i_ref_clk(clk), .o_cs_n(cs_n), .o_ds_n(ds_n), .o_rd_wr(rd_wr),
    .o_addr(addr), .i_data(data), .i_dta_n(dta_n), .i_sel(sel));
  // ****************************************
  // compare and bus helpers
  // ****************************************
  task automatic check_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_flags(input string nm, input logic [3:0] e, input logic [3:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic xfer(input logic [2:0] ms, input logic [14:0] a, input logic rd,
                      output logic [15:0] d, output logic [3:0] s);
    @(posedge clk);
    msel <= ms;
    host_u.access(a, rd, d, s);
  endtask
  // acked read of a receive memory word
  task automatic rdchk(input logic [2:0] ms, input logic [14:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic [3:0]  s;
    xfer(ms, a, 1'b1, d, s);
    check_flags("read ack", 4'b0001, s);
    check_word("read word", e, d);
    check_word("read drive", 16'h0001, {15'h0, oe_seen});
  endtask
  // first bit sent is the msb, so a reversed store shows up
  task automatic send_byte(input int sd, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      rx_bit[sd] <= b[i];
      repeat (3) @(posedge clk);
      rx_stb[sd] <= 1'b1;
      repeat (3) @(posedge clk);
      rx_stb[sd] <= 1'b0;
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_space();
    logic [15:0] d;
    logic [3:0]  s;
    xfer(MS_LOC_ROUTE, 15'h0005, 1'b1, d, s);
    check_flags("register space", 4'b1000, s);
    xfer(MS_LOC_ROUTE, 15'h4005, 1'b1, d, s);
    check_flags("local route", 4'b0100, s);
    xfer(MS_BP_ROUTE, 15'h4005, 1'b0, d, s);
    check_flags("backplane route", 4'b0010, s);
    rdchk(3'h5, 15'h4005, 16'h0000);
  endtask
  task automatic t_receive();
    for (int sd = 0; sd < 2; sd++) begin
      @(posedge clk);
      rx_frame[sd] <= 1'b1;
      repeat (3) @(posedge clk);
      rx_frame[sd] <= 1'b0;
      send_byte(sd, 8'h1e);
      send_byte(sd, 8'hc4);
    end
    repeat (10) @(posedge clk);
    check_word("overrun", 16'h0000, {14'h0, ovr});
    rdchk(MS_LOC_DATA, {1'b1, 5'h00, 9'h000}, 16'h001e);
    rdchk(MS_LOC_DATA, {1'b1, 5'h00, 9'h001}, 16'h00c4);
    rdchk(MS_BP_DATA, {1'b1, 5'h00, 9'h000}, 16'h001e);
    rdchk(MS_BP_DATA, {1'b1, 5'h00, 9'h001}, 16'h00c4);
  endtask
  task automatic t_write();
    logic [15:0] d;
    logic [3:0]  s;
    xfer(MS_LOC_DATA, {1'b1, 5'h00, 9'h000}, 1'b0, d, s);
    check_flags("local write ack", 4'b0001, s);
    check_word("write drive", 16'h0000, {15'h0, oe_seen});
    rdchk(MS_LOC_DATA, {1'b1, 5'h00, 9'h000}, 16'h001e);
    xfer(MS_BP_DATA, {1'b1, 5'h00, 9'h001}, 1'b0, d, s);
    check_flags("backplane write ack", 4'b0001, s);
    rdchk(MS_BP_DATA, {1'b1, 5'h00, 9'h001}, 16'h00c4);
  endtask
  task automatic t_range();
    rdchk(MS_LOC_DATA, {1'b1, 5'h10, 9'h000}, 16'h0000);
    rdchk(MS_BP_DATA, {1'b1, 5'h00, 9'h020}, 16'h0000);
    @(posedge clk);
    rx_rate[0] <= RATE_32M;
    repeat (4) @(posedge clk);
    rdchk(MS_LOC_DATA, {1'b1, 5'h08, 9'h000}, 16'h0000);
  endtask
  // ****************************************
  // sequence, watchdog and verdict
  // ****************************************
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_space();
    t_receive();
    t_write();
    t_range();
    report_and_stop();
  end
  // whole run needs a few hundred cycles
  initial begin
    #2000000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: tma_pkg.sv
// Purpose: shared constants and types of the timeslot memory access map
// Assumes: one 10 MHz system clock, synchronous active-high reset
// Notes:   offsets, field positions and counts live here only
package tma_pkg;
  // ****************************************
  // host address layout
  // ****************************************
  localparam int ADDR_W   = 15;
  localparam int SPACE_B  = 14;
  localparam int STRM_HI  = 13;
  localparam int STRM_LO  = 9;
  localparam int CHAN_W   = 9;
  localparam int BYTE_W   = 8;
  localparam int WORD_W   = 16;
  localparam int LOC_DEPTH = 4096;
  localparam int BP_DEPTH  = 8192;
  localparam int IDX_W    = 13;
  localparam logic [7:0] RSVD_HI = 8'h00;

  // ****************************************
  // memory select field codes
  // ****************************************
  localparam logic [2:0] MS_LOC_ROUTE = 3'h0;
  localparam logic [2:0] MS_BP_ROUTE  = 3'h1;
  localparam logic [2:0] MS_LOC_DATA  = 3'h2;
  localparam logic [2:0] MS_BP_DATA   = 3'h3;

  // ****************************************
  // stream rates and limits
  // ****************************************
  localparam logic [2:0] RATE_2M  = 3'h0;
  localparam logic [2:0] RATE_32M = 3'h4;
  localparam logic [8:0] CHAN_BASE = 9'h020;
  localparam logic [4:0] LOC_SMAX   = 5'h0f;
  localparam logic [4:0] BP_SMAX    = 5'h1f;
  localparam logic [4:0] LOC_SMAX32 = 5'h07;
  localparam logic [4:0] BP_SMAX32  = 5'h0f;

  // ****************************************
  // receive path fifo
  // ****************************************
  localparam int FIFO_DEPTH = 32;
  localparam int ENTRY_W    = 1 + IDX_W + BYTE_W;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_HOLD = 3'b010,
    HS_PASS = 3'b100
  } tma_host_st_t;
endpackage
